// [include/adc_seq_pkg.sv]
// Shared constants and types for the simultaneous-sampling converter sequencer.
package adc_seq_pkg;
	// Clock and timing figures.
	localparam int CLK_PERIOD_NS = 50;
	localparam int CONV_TIME_NS  = 2400;
	localparam int EOC_LOW_NS    = 150;
	// Cycle counts derived from the figures above, rounded up.
	localparam int CONV_CYC = (CONV_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int EOC_CYC  = (EOC_LOW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	// Widths and counts.
	localparam int RESULT_W = 14;
	localparam int NUM_CH   = 4;
	localparam int PTR_W    = 2;
	localparam int CNT_W    = 6;
	localparam int EOC_W    = 2;
	localparam int SYNC_W   = 8;
	// Positions of the pins inside the synchroniser vector.
	localparam int SYN_START = 0;
	localparam int SYN_CS    = 1;
	localparam int SYN_RD    = 2;
	localparam int SYN_SRC   = 3;
	localparam int SYN_SEL   = 4;
	// Values after reset, and the last counts of the two timers.
	localparam logic [SYNC_W-1:0]   SYNC_RST   = 8'h07;
	localparam logic [PTR_W-1:0]    PTR_RST    = 2'h0;
	localparam logic [RESULT_W-1:0] RESULT_RST = 14'h0000;
	localparam logic [CNT_W-1:0]    CNT_LAST   = 6'(CONV_CYC - 1);
	localparam logic [EOC_W-1:0]    EOC_LAST   = 2'(EOC_CYC - 1);
	// Sequencer states.
	typedef enum logic {
		SEQ_IDLE,
		SEQ_CONV
	} seq_state_t;
endpackage

// [hw/pin_sync.sv]
// Two-stage synchroniser for a group of asynchronous pins.
`timescale 1ns/1ps
module pin_sync #(
	parameter int                W       = 8,
	parameter logic [W-1:0]      RST_VAL = '0
) (
	// Clock and reset.
	input  wire logic         ref_clk,
	input  wire logic         resetn,
	// Raw pins and their synchronised copies.
	input  wire logic [W-1:0] pin_in,
	output logic      [W-1:0] pin_sync_out
);
	// First stage; only the second stage reads it, so metastability cannot spread.
	logic [W-1:0] meta_q;
	// Each bit gets its own pair of flip-flops.
	for (genvar i = 0; i < W; i++) begin : g_bit
		always_ff @(posedge ref_clk) begin
			if (!resetn) begin
				meta_q[i]       <= RST_VAL[i];
				pin_sync_out[i] <= RST_VAL[i];
			end else begin
				meta_q[i]       <= pin_in[i];
				pin_sync_out[i] <= meta_q[i];
			end
		end
	end
endmodule // pin_sync

// [hw/result_bank.sv]
// Four output data registers holding the results of one conversion sequence.
`timescale 1ns/1ps
module result_bank (
	// Clock and reset.
	input  wire logic                                   ref_clk,
	input  wire logic                                   resetn,
	// Write side, used at the end of each conversion.
	input  wire logic                                   wr_en,
	input  wire logic [adc_seq_pkg::PTR_W-1:0]          wr_idx,
	input  wire logic [adc_seq_pkg::RESULT_W-1:0]       wr_data,
	// Read side, addressed by the read pointer.
	input  wire logic [adc_seq_pkg::PTR_W-1:0]          rd_idx,
	output logic      [adc_seq_pkg::RESULT_W-1:0]       rd_data
);
	// The result storage itself.
	logic [adc_seq_pkg::RESULT_W-1:0] mem_q [adc_seq_pkg::NUM_CH];

	// Store a new result; old results stay until overwritten so they can be reread.
	always_ff @(posedge ref_clk) begin
		if (!resetn) begin
			for (int i = 0; i < adc_seq_pkg::NUM_CH; i++) begin
				mem_q[i] <= adc_seq_pkg::RESULT_RST;
			end
		end else if (wr_en) begin
			mem_q[wr_idx] <= wr_data;
		end
	end

	// Plain combinational read; the caller registers the bus value.
	assign rd_data = mem_q[rd_idx];
endmodule // result_bank

// [hw/adc_seq_readout.sv]
// Conversion sequencer and circular result readout for a four-channel sampling converter.
`timescale 1ns/1ps
module adc_seq_readout (
	// Clock and reset.
	input  wire logic                                   ref_clk,
	input  wire logic                                   resetn,
	// Conversion control pins.
	input  wire logic                                   conversion_start_n,
	input  wire logic                                   hw_sw_select,
	input  wire logic [adc_seq_pkg::NUM_CH-1:0]         channel_select_pins,
	input  wire logic [adc_seq_pkg::NUM_CH-1:0]         sw_channel_mask,
	// Parallel read bus pins.
	input  wire logic                                   chip_select_n,
	input  wire logic                                   read_strobe_n,
	output logic      [adc_seq_pkg::RESULT_W-1:0]       data_bus_out,
	output logic                                        data_bus_oe,
	// Status pins.
	output logic                                        end_of_conv_n,
	output logic                                        busy,
	output logic                                        first_word_flag,
	// Converter core.
	input  wire logic [adc_seq_pkg::RESULT_W-1:0]       core_result,
	output logic                                        track_hold,
	output logic      [adc_seq_pkg::PTR_W-1:0]          conv_channel
);
	// All sequencer state in one record.
	typedef struct packed {
		adc_seq_pkg::seq_state_t             st;         // Sequencer state.
		logic [adc_seq_pkg::CNT_W-1:0]       cnt;        // Conversion timer.
		logic [adc_seq_pkg::EOC_W-1:0]       eoc_cnt;    // Low time of the end pulse.
		logic [adc_seq_pkg::NUM_CH-1:0]      mask;       // Latched channel mask.
		logic [adc_seq_pkg::PTR_W-1:0]       chan;       // Channel being converted.
		logic [2:0]                          stored;     // Results done this sequence.
		logic [2:0]                          total;      // Channels selected.
		logic [adc_seq_pkg::PTR_W-1:0]       ptr;        // Read pointer.
		logic                                pend;       // Deferred pointer advance.
		logic                                eoc_n;      // End-of-conversion pin.
		logic                                busy;       // Busy pin.
		logic                                first;      // First-word flag pin.
		logic                                hold;       // Track/hold control.
		logic                                start_prev; // Start pin one cycle ago.
		logic                                rd_act;     // Select and strobe both low.
		logic                                oe;         // Data bus enable.
		logic [adc_seq_pkg::RESULT_W-1:0]    dout;       // Data bus value.
	} seq_reg_t;

	seq_reg_t                               q;          // Registered state.
	seq_reg_t                               d;          // Next state.
	logic [adc_seq_pkg::SYNC_W-1:0]         pins_s;     // Synchronised pins.
	logic                                   start_s;    // Synchronised start pin.
	logic                                   cs_s;       // Synchronised chip select.
	logic                                   rd_s;       // Synchronised read strobe.
	logic                                   src_s;      // Synchronised source select.
	logic [adc_seq_pkg::NUM_CH-1:0]         sel_s;      // Synchronised select pins.
	logic [adc_seq_pkg::NUM_CH-1:0]         new_mask;   // Mask offered at a start.
	logic                                   start_edge; // Rising start edge seen.
	logic                                   start_take; // Start accepted.
	logic                                   rd_edge;    // Rising strobe ending a read.
	logic                                   complete;   // A conversion ends this cycle.
	logic [adc_seq_pkg::RESULT_W-1:0]       bank_rdata; // Register at the pointer.

	// Every pin except sw_channel_mask, core_result and resetn passes two flip-flops before any logic sees it.
	pin_sync #(
		.W       (adc_seq_pkg::SYNC_W),
		.RST_VAL (adc_seq_pkg::SYNC_RST)
	) u_sync (
		.ref_clk      (ref_clk),
		.resetn       (resetn),
		.pin_in       ({channel_select_pins, hw_sw_select, read_strobe_n, chip_select_n, conversion_start_n}),
		.pin_sync_out (pins_s)
	);

	assign start_s = pins_s[adc_seq_pkg::SYN_START];
	assign cs_s    = pins_s[adc_seq_pkg::SYN_CS];
	assign rd_s    = pins_s[adc_seq_pkg::SYN_RD];
	assign src_s   = pins_s[adc_seq_pkg::SYN_SRC];
	assign sel_s   = pins_s[adc_seq_pkg::SYN_SEL +: adc_seq_pkg::NUM_CH];

	// The output registers; a result is written in the cycle the end pulse is launched.
	result_bank u_bank (
		.ref_clk (ref_clk),
		.resetn  (resetn),
		.wr_en   (complete),
		.wr_idx  (q.stored[adc_seq_pkg::PTR_W-1:0]),
		.wr_data (core_result),
		.rd_idx  (q.ptr),
		.rd_data (bank_rdata)
	);

	// Lowest selected channel at or above a given one; four means none is left.
	function automatic logic [2:0] find_ch(input logic [3:0] m, input logic [2:0] lo);
		logic [2:0] r;
		r = 3'h4;
		for (int i = 3; i >= 0; i--) begin
			if (m[i] && 3'(i) >= lo) begin
				r = 3'(i);
			end
		end
		return r;
	endfunction

	// Events decoded from the current state and the synchronised pins.
	always_comb begin
		new_mask   = src_s ? sw_channel_mask : sel_s;
		start_edge = !q.start_prev && start_s;
		start_take = start_edge && !q.busy && new_mask != 4'h0;
		rd_edge    = q.rd_act && rd_s;
		complete   = q.st == adc_seq_pkg::SEQ_CONV && q.cnt == adc_seq_pkg::CNT_LAST;
	end

	// Next-state logic; the completion is applied before the read so a read in the
	// same cycle already sees the new result as valid.
	always_comb begin
		logic [2:0] ch;
		ch = 3'h0;
		d = q;
		d.start_prev = start_s;
		d.rd_act     = !cs_s && !rd_s;
		// The bus is enabled only while both select and strobe are low.
		d.oe   = !cs_s && !rd_s;
		d.dout = bank_rdata;
		// Finish the end-of-conversion low time.
		if (!q.eoc_n) begin
			if (q.eoc_cnt == adc_seq_pkg::EOC_LAST) begin
				d.eoc_n = 1'b1;
			end else begin
				d.eoc_n   = 1'b0;
				d.eoc_cnt = q.eoc_cnt + 2'h1;
			end
		end
		if (q.st == adc_seq_pkg::SEQ_IDLE) begin
			// A start freezes every channel and latches the mask.
			if (start_take) begin
				ch      = find_ch(new_mask, 3'h0);
				d.st    = adc_seq_pkg::SEQ_CONV;
				d.mask  = new_mask;
				d.total = {2'h0, new_mask[0]} + {2'h0, new_mask[1]}
				        + {2'h0, new_mask[2]} + {2'h0, new_mask[3]};
				d.chan   = ch[1:0];
				d.cnt    = '0;
				d.stored = 3'h0;
				d.pend   = 1'b0;
				d.busy   = 1'b1;
				d.hold   = 1'b1;
			end
		end else begin
			d.cnt = q.cnt + 6'h01;
			if (complete) begin
				d.cnt     = '0;
				d.eoc_n   = 1'b0;
				d.eoc_cnt = '0;
				d.stored  = q.stored + 3'h1;
				if (q.stored == 3'h0) begin
					// Pointer and flag move just as the first pulse starts.
					d.ptr   = adc_seq_pkg::PTR_RST;
					d.first = 1'b1;
				end else if (q.pend) begin
					// An earlier read was waiting for this result.
					d.ptr   = q.ptr + 2'h1;
					d.pend  = 1'b0;
					d.first = 1'b0;
				end
				ch = find_ch(q.mask, {1'b0, q.chan} + 3'h1);
				if (d.stored == q.total) begin
					// Busy falls together with the last pulse.
					d.st   = adc_seq_pkg::SEQ_IDLE;
					d.busy = 1'b0;
					d.hold = 1'b0;
				end else begin
					d.chan = ch[1:0];
				end
			end
		end
		// Pointer movement at the end of a read.
		if (rd_edge) begin
			if (d.stored != 3'h0 && d.stored == d.total && {1'b0, d.ptr} == d.stored - 3'h1) begin
				// The last result was read; wrap so the next read sees the first.
				d.ptr   = adc_seq_pkg::PTR_RST;
				d.first = 1'b1;
				d.pend  = 1'b0;
			end else if ({1'b0, d.ptr} + 3'h1 < d.stored) begin
				d.ptr   = d.ptr + 2'h1;
				d.first = 1'b0;
			end else if (d.busy && d.stored != 3'h0) begin
				// Next result not ready yet; remember one advance only.
				d.pend = 1'b1;
			end
		end
	end

	// State register; the flag simply starts low, the host must not trust it yet.
	always_ff @(posedge ref_clk) begin
		if (!resetn) begin
			q            <= '0;
			q.st         <= adc_seq_pkg::SEQ_IDLE;
			q.eoc_n      <= 1'b1;
			q.start_prev <= 1'b1;
			q.first      <= 1'b0;
		end else begin
			q <= d;
		end
	end

	// Every output comes straight from the state register.
	assign data_bus_out    = q.dout;
	assign data_bus_oe     = q.oe;
	assign end_of_conv_n   = q.eoc_n;
	assign busy            = q.busy;
	assign first_word_flag = q.first;
	assign track_hold      = q.hold;
	assign conv_channel    = q.chan;

	// Assertion timing in cycles.
	localparam int CONV_D  = adc_seq_pkg::CONV_CYC;
	localparam int FIRST_D = adc_seq_pkg::CONV_CYC + 1;

	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!resetn);

	// A taken start raises busy and hold on the next edge.
	a_start_busy_hold: assert property (start_take |=> q.busy && q.hold)
		else $error("busy or hold not raised after start");
	// The first result pulse comes one conversion time plus one cycle after the start is taken.
	a_first_conv_time: assert property (start_take |-> ##FIRST_D $fell(q.eoc_n))
		else $error("first end pulse at wrong time");
	// Further pulses follow at the conversion interval while busy.
	a_conv_interval: assert property ($fell(q.eoc_n) && q.busy |-> ##CONV_D $fell(q.eoc_n))
		else $error("conversion interval wrong");
	// The end pulse lasts exactly its low time.
	a_eoc_width: assert property ($fell(q.eoc_n) |-> !q.eoc_n [*3] ##1 q.eoc_n)
		else $error("end pulse width wrong");
	// Busy only falls together with the last end pulse.
	a_busy_last: assert property ($fell(q.busy) |-> $fell(q.eoc_n) && q.stored == q.total)
		else $error("busy fell away from last pulse");
	// The bus is enabled only after select and strobe were both low.
	a_bus_gate: assert property (q.oe |-> $past(!cs_s && !rd_s))
		else $error("bus enabled without select and strobe");
	// After the first pulse the pointer addresses the first register, flag high.
	a_first_ptr: assert property ($fell(q.eoc_n) && q.stored == 3'h1 |-> q.ptr == 2'h0 && q.first)
		else $error("pointer not reset at first result");
	// A start during a sequence leaves the mask untouched.
	a_start_ignore: assert property (start_edge && q.busy |=> $stable(q.mask))
		else $error("mask changed by start while busy");
	// Reading the last result of a finished sequence wraps the pointer.
	a_ptr_wrap: assert property (rd_edge && !q.busy && q.stored == q.total && q.stored != 3'h0
		&& {1'b0, q.ptr} == q.stored - 3'h1 |=> q.ptr == 2'h0 && q.first)
		else $error("pointer did not wrap after last read");
	// Once a result is stored, the pointer never addresses a result not yet written this sequence.
	a_ptr_valid: assert property (q.stored != 3'h0 |-> {1'b0, q.ptr} < q.stored)
		else $error("pointer beyond valid results");

	// Pointer movement checks; a start in the same cycle clears the stored count,
	// so reads that coincide with a start are left out of the after-busy check.
	// A deferred advance lands on the next completion and clears the flag.
	a_defer_advance: assert property (q.pend && complete && q.stored != 3'h0 && !rd_edge
		|=> q.ptr == $past(q.ptr) + 2'h1 && !q.first)
		else $error("deferred advance not applied at completion");
	// A read ending before the next result exists leaves the pointer where it is.
	a_early_hold: assert property (rd_edge && q.busy && !complete && {1'b0, q.ptr} + 3'h1 >= q.stored
		|=> $stable(q.ptr))
		else $error("pointer moved before next result was ready");
	// After busy, a read with a further result advances the pointer and drops the flag.
	a_first_drop: assert property (rd_edge && !q.busy && !start_take && {1'b0, q.ptr} + 3'h1 < q.stored
		|=> q.ptr == $past(q.ptr) + 2'h1 && !q.first)
		else $error("pointer or flag wrong after read");
	// Every conversion but the last moves on to a higher channel.
	a_channel_order: assert property (complete && q.stored + 3'h1 != q.total |=> q.chan > $past(q.chan))
		else $error("channels not converted in ascending order");
	// No end pulse beyond the number of selected channels.
	a_pulse_bound: assert property ($fell(q.eoc_n) |-> q.stored != 3'h0 && q.stored <= q.total)
		else $error("more end pulses than selected channels");

	// A full four-channel sequence.
	c_four_channels: cover property (start_take && new_mask == 4'hf);
	// A read deferred until the next conversion ends.
	c_deferred_read: cover property (q.pend && complete);
	// A wrap back to the first result.
	c_wrap: cover property (rd_edge && !q.busy && q.stored == q.total && {1'b0, q.ptr} == q.stored - 3'h1);
	// A start edge arriving while a sequence runs.
	c_ignored_start: cover property (start_edge && q.busy);
	// A sequence of a single channel.
	c_single_channel: cover property (complete && q.total == 3'h1);
endmodule // adc_seq_readout

// [tb/bus_host_model.sv]
// Host processor model that starts conversions and reads results over the parallel bus.
`timescale 1ns/1ps
module bus_host_model (
	// Clock.
	input  wire logic                                ref_clk,
	// Device outputs seen by the host.
	input  wire logic [adc_seq_pkg::RESULT_W-1:0]    data_bus_out,
	input  wire logic                                data_bus_oe,
	// Host-driven pins.
	output logic                                     chip_select_n,
	output logic                                     read_strobe_n,
	output logic                                     conversion_start_n
);
	bit cs_tied; // When set, select stays low after the first read.

	// All pins idle high at time zero so the synchronisers see no edge.
	initial begin
		chip_select_n      = 1'b1;
		read_strobe_n      = 1'b1;
		conversion_start_n = 1'b1;
		cs_tied            = 1'b0;
	end

	// Pulse the start pin low for three cycles; the rising edge starts a sequence.
	task automatic start_pulse();
		@(negedge ref_clk);
		conversion_start_n <= 1'b0;
		repeat (3) @(negedge ref_clk);
		conversion_start_n <= 1'b1;
	endtask

	// One read: hold select and strobe until the enable is seen at an edge, then three cycles more, then release the strobe, and the select unless tied.
	task automatic read_word(output logic [adc_seq_pkg::RESULT_W-1:0] word, output bit ok);
		int n;
		ok   = 1'b0;
		word = '0;
		n    = 0;
		@(negedge ref_clk);
		chip_select_n <= 1'b0;
		read_strobe_n <= 1'b0;
		while (!ok && n < 20) begin
			@(posedge ref_clk);
			n++;
			if (data_bus_oe === 1'b1) begin
				word = data_bus_out;
				ok   = 1'b1;
			end
		end
		repeat (3) @(posedge ref_clk);
		@(negedge ref_clk);
		read_strobe_n <= 1'b1;
		if (!cs_tied) begin
			chip_select_n <= 1'b1;
		end
		// Spacing after the read also gives the quiet time before any start.
		repeat (6) @(negedge ref_clk);
	endtask
endmodule // bus_host_model

// [tb/simultaneous_adc_sequence_readout_bench.sv]
// Self-checking bench for the converter sequencer and circular result readout.
`timescale 1ns/1ps
module simultaneous_adc_sequence_readout_bench;
	logic                                ref_clk, resetn, hw_sw_select;
	logic [adc_seq_pkg::NUM_CH-1:0]      channel_select_pins, sw_channel_mask;
	logic [adc_seq_pkg::RESULT_W-1:0]    core_result, data_bus_out;
	logic                                chip_select_n, read_strobe_n, conversion_start_n;
	logic                                data_bus_oe, end_of_conv_n, busy, first_word_flag, track_hold;
	logic [adc_seq_pkg::PTR_W-1:0]       conv_channel;
	logic [adc_seq_pkg::RESULT_W-1:0]    ch_val [adc_seq_pkg::NUM_CH]; // Core value per channel.
	logic [15:0]                         lfsr_q;                       // Random source state.
	logic                                eoc_prev, busy_prev;
	int                                  miscompares, checked, cyc, t_busy, t_last, n_falls, bad;

	adc_seq_readout uut (.ref_clk(ref_clk), .resetn(resetn), .conversion_start_n(conversion_start_n),
		.hw_sw_select(hw_sw_select), .channel_select_pins(channel_select_pins),
		.sw_channel_mask(sw_channel_mask), .chip_select_n(chip_select_n), .read_strobe_n(read_strobe_n),
		.data_bus_out(data_bus_out), .data_bus_oe(data_bus_oe), .end_of_conv_n(end_of_conv_n),
		.busy(busy), .first_word_flag(first_word_flag), .core_result(core_result),
		.track_hold(track_hold), .conv_channel(conv_channel));

	bus_host_model host (.ref_clk(ref_clk), .data_bus_out(data_bus_out), .data_bus_oe(data_bus_oe),
		.chip_select_n(chip_select_n), .read_strobe_n(read_strobe_n),
		.conversion_start_n(conversion_start_n));

	// Free-running clock, 50 ns period.
	initial begin
		ref_clk = 1'b0;
		forever #25 ref_clk = ~ref_clk;
	end

	// Core answers with the value of the channel it is converting, changed off the sampling edge.
	always @(negedge ref_clk) begin
		core_result <= ch_val[conv_channel];
	end

	// Timing monitor: every end pulse must come 48 cycles after busy rose or after the previous one.
	always @(posedge ref_clk) begin
		cyc++;
		if (busy === 1'b1 && busy_prev === 1'b0) t_busy = cyc;
		if (busy === 1'b1 && track_hold !== 1'b1) bad++;
		if (end_of_conv_n === 1'b0 && eoc_prev === 1'b1) begin
			if (((n_falls == 0) ? t_busy : t_last) + adc_seq_pkg::CONV_CYC != cyc) bad++;
			n_falls++;
			t_last = cyc;
		end
		if (busy === 1'b0 && busy_prev === 1'b1 && cyc != t_last) bad++;
		eoc_prev  = end_of_conv_n;
		busy_prev = busy;
	end

	// Galois-free shift register step used for all random stimulus.
	function automatic logic [15:0] lfsr_step(input logic [15:0] s);
		return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
	endfunction

	// Compare and count; a mismatch is reported at once.
	task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
		checked++;
		if (seen !== exp) begin
			miscompares++;
			$display("mismatch %s expected %h seen %h", what, exp, seen);
		end
	endtask

	// Wait for a number of end pulses, bounded so a silent device cannot hang the run.
	task automatic wait_falls(input int n);
		int k;
		k = 0;
		while (n_falls < n && k < 300) begin
			@(posedge ref_clk);
			k++;
		end
		repeat (2) @(negedge ref_clk);
	endtask

	// One read through the host, compared against the expected result.
	task automatic read_check(input string what, input logic [adc_seq_pkg::RESULT_W-1:0] exp);
		logic [adc_seq_pkg::RESULT_W-1:0] w;
		bit                               ok;
		host.read_word(w, ok);
		check("read handshake", 32'(ok), 32'h1);
		check(what, 32'(w), 32'(exp));
		check("bus released", 32'(data_bus_oe), 32'h0);
	endtask

	// One sequence: load channel values, start, optionally read during it, then read around the ring.
	task automatic run_seq(input logic [3:0] mask, input bit src, input bit early);
		logic [adc_seq_pkg::RESULT_W-1:0] exp_q [$];
		int                               k, idx;
		idx = 0;
		for (k = 0; k < 4; k++) begin
			lfsr_q    = lfsr_step(lfsr_q);
			ch_val[k] = lfsr_q[13:0];
			if (mask[k]) exp_q.push_back(lfsr_q[13:0]); // Ascending channel order.
		end
		// The source not chosen carries the inverse mask, so a wrong selection shows.
		@(negedge ref_clk);
		hw_sw_select        <= src;
		channel_select_pins <= src ? ~mask : mask;
		sw_channel_mask     <= src ? mask : ~mask;
		n_falls = 0;
		bad     = 0;
		host.start_pulse();
		if (early) begin
			wait_falls(1);
			check("flag after first result", 32'(first_word_flag), 32'h1);
			read_check("read in first gap", exp_q[0]);
			@(negedge ref_clk);
			channel_select_pins <= 4'h1;
			host.start_pulse(); // Ignored while busy; mask kept.
			read_check("repeat read before next result", exp_q[0]);
			wait_falls(2);
			check("flag after deferred advance", 32'(first_word_flag), 32'h0);
			read_check("read after deferred advance", exp_q[1]);
			idx = 2;
		end
		wait_falls(exp_q.size());
		check("end pulse count", 32'(n_falls), 32'(exp_q.size()));
		check("timing faults", 32'(bad), 32'h0);
		check("busy after last", 32'(busy), 32'h0);
		if (!early) check("flag at end", 32'(first_word_flag), 32'h1);
		for (k = idx; k <= idx + exp_q.size(); k++) begin
			read_check("ring read", exp_q[k % exp_q.size()]);
			// The flag is high only after the read that returns the last result.
			if (k == idx) check("flag after first read", 32'(first_word_flag),
				32'((idx % exp_q.size()) == exp_q.size() - 1));
			if ((k % exp_q.size()) == exp_q.size() - 1) check("flag after wrap", 32'(first_word_flag), 32'h1);
		end
	endtask

	// Print counts and the verdict, then end the run.
	task automatic report_and_stop();
		$display("counts: %0d mismatches in %0d comparisons", miscompares, checked);
		if (miscompares == 0 && checked > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask

	// Watchdog sized well beyond the fewer than two thousand cycles the sequences need.
	initial begin
		repeat (20000) @(posedge ref_clk);
		miscompares++;
		report_and_stop();
	end

	// Main sequence: reset, fixed corner cases, then random masks with the select tied low.
	initial begin
		logic [3:0] m;
		resetn = 1'b0;
		hw_sw_select = 1'b0;
		channel_select_pins = 4'h0;
		sw_channel_mask = 4'h0;
		ch_val = '{default: 14'h0000};
		core_result = 14'h0000;
		lfsr_q = 16'hf11b;
		{miscompares, checked, cyc, t_busy, t_last, n_falls, bad} = '0;
		eoc_prev = 1'b1;
		busy_prev = 1'b0;
		repeat (3) @(posedge ref_clk);
		@(negedge ref_clk);
		resetn <= 1'b1;
		@(negedge ref_clk);
		check("reset end pulse", 32'(end_of_conv_n), 32'h1);
		check("reset busy", 32'(busy), 32'h0);
		check("reset bus enable", 32'(data_bus_oe), 32'h0);
		run_seq(4'hf, 1'b0, 1'b0);
		run_seq(4'hd, 1'b1, 1'b0);
		run_seq(4'hf, 1'b0, 1'b1);
		host.cs_tied = 1'b1;
		for (int i = 0; i < 5; i++) begin
			lfsr_q = lfsr_step(lfsr_q);
			m = (lfsr_q[3:0] == 4'h0) ? 4'h8 : lfsr_q[3:0];
			run_seq(m, lfsr_q[4], 1'b0);
		end
		report_and_stop();
	end
endmodule // simultaneous_adc_sequence_readout_bench
